//--- common/wdt_pkg.sv
/*
  watchdog and address-trap constants: register offsets, control codes,
  field positions, reset values and timing counts.
  assumes a 250 MHz system clock and a 32-bit apb register bus.
*/
package wdt_pkg;
  // register byte offsets on apb
  localparam logic [7:0] cfg_offset       = 8'h00;
  localparam logic [7:0] code_offset      = 8'h04;
  localparam logic [7:0] status_offset    = 8'h08;
  localparam logic [7:0] fetch_offset     = 8'h0C;
  // control codes written to watchdog_control_code
  localparam logic [7:0] trap_arm_code    = 8'hD2;
  localparam logic [7:0] clear_code       = 8'h4E;
  localparam logic [7:0] disable_code     = 8'hB1;
  // watchdog_config_reg field positions
  localparam int         out_sel_pos      = 0;
  localparam int         time_lsb_pos     = 1;
  localparam int         enable_pos       = 3;
  localparam int         trap_resp_pos    = 4;
  localparam int         ram_trap_pos     = 5;
  localparam int         div_src_pos      = 6;
  localparam int         slow_mode_pos    = 7;
  // watchdog_config_reg reset value (enable=1, time=00, output=reset)
  localparam logic [7:0] cfg_reset        = 8'h39;
  // overflow exponents for detection code 00, fast and slow clock
  localparam int         fast_exp_00      = 25;
  localparam int         slow_exp_00      = 17;
  // prescaler taps: period splits into divider and 2-stage binary counter
  localparam int         binary_bits      = 2;
  // reset pulse length in fast-clock periods, at most
  localparam int         reset_fc_periods = 24;
  localparam int         fc_mhz           = 16;
  localparam int         clk_mhz          = 250;
  // longest reset time in ns, rounded down to whole clocks
  localparam int         reset_ns         = reset_fc_periods * 1000 / fc_mhz;
  localparam int         reset_cycles     = reset_ns * clk_mhz / 1000;
  // address areas
  localparam logic [15:0] sfr_base        = 16'h0000;
  localparam logic [15:0] sfr_last        = 16'h003F;
  localparam logic [15:0] ram_base        = 16'h0040;
  localparam logic [15:0] ram_last        = 16'h023F;
  localparam logic [15:0] dbg_base        = 16'h0F80;
  localparam logic [15:0] dbg_last        = 16'h0FFF;
endpackage : wdt_pkg

//--- rtl/wdt_pulse_stretch.sv
/*
  holds a request output high for a fixed number of clocks after a trigger.
  assumes trigger is synchronous to clock.
*/
`timescale 1ns/10ps
`default_nettype none
module wdt_pulse_stretch #(
  parameter int LENGTH = 4
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // trigger and stretched output
  input  wire logic trigger,
  output logic      active
);
  logic [15:0] count_q;

  // count down from length on trigger; retrigger restarts
  always_ff @(posedge clock)
  begin
    if (!nrst)
      count_q <= 16'h0000;
    else if (trigger)
      count_q <= 16'(LENGTH);
    else if (count_q != 16'h0000)
      count_q <= count_q - 16'h0001;
  end

  assign active = (count_q != 16'h0000);
endmodule : wdt_pulse_stretch
`default_nettype wire

//--- rtl/wdt_trap.sv
/*
  watchdog timer with protected disable and address-trap monitor,
  software reaches it over apb; cpu fetch address arrives each cycle.
  assumes fetch and mode inputs are synchronous to clock and that the
  interrupt controller takes single-cycle nmi pulses without masking.
*/
// Our own choices: the register offsets and the APB interface to the registers.
// Operation
// (RULE1) software disables by: clear master enable, clear code, enable off, disable code
// (RULE2) counter stages held at zero while watchdog disabled
// (RULE3) detection field picks overflow period 2^25,2^23,2^21,2^19 fast clocks
// (RULE4) overflow with output select 0 raises watchdog interrupt
// (RULE5) watchdog interrupt is non-maskable
// (RULE6) new watchdog interrupt nests at once over any serviced one
// (RULE7) software loads stack pointer before choosing interrupt response
// (RULE8) overflow with output select 1 resets hardware, at most 24 fast clocks
// (RULE9) code register: D2 arms trap select, 4E clears, B1 disables
// (RULE10) new ram-trap select takes effect only after D2 written
// (RULE11) fetch from sfr or debug area always traps
// (RULE12) trap response bit picks interrupt or reset
// (RULE13) response 0: trap interrupt; ram trapped only when select is 1
// (RULE14) trap interrupt non-maskable and nests immediately
// (RULE15) response 1: trapped fetch resets hardware, at most 24 fast clocks
// (RULE16) software sets stack pointer before enabling trap interrupts
// (RULE17) disable code acts only while enable bit is already 0
// (RULE18) output select once cleared stays 0 until reset
// (RULE19) clear code resets binary counter only, prescaler keeps running
// (RULE20) each interrupt request is a single-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module wdt_trap #(
  parameter int FC_DIV = 16 // system clocks per fast-clock period
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu fetch monitor
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_addr,
  // operating mode from clock controller
  input  wire logic        slow_mode,
  input  wire logic        counting_hold,
  // requests to interrupt and reset controller
  output logic             watchdog_irq,
  output logic             address_trap_irq,
  output logic             reset_request,
  output logic             fast_osc_restart
);
  localparam int DIV_W = 32;

  logic              wr_en;
  logic              rd_en;
  logic              enable_bit_q;
  logic              output_select_bit_q;
  logic [1:0]        detection_time_field_q;
  logic              trap_response_bit_q;
  logic              ram_trap_pending_q;
  logic              ram_trap_select_bit_q;
  logic              divider_source_select_q;
  logic              wdt_on_q;
  logic [DIV_W-1:0]  fc_cnt_q;
  logic              fc_tick;
  logic [DIV_W-1:0]  prescale_q;
  logic [DIV_W-1:0]  prescale_d;
  logic [1:0]        binary_q;
  logic              stage_tick;
  logic              overflow;
  logic              trap_hit;
  logic              in_sfr;
  logic              in_ram;
  logic              in_dbg;
  logic              reset_trigger;
  logic              reset_active;
  logic [7:0]        code;
  logic [7:0]        cfg;
  logic [15:0]       last_trap_addr_q;
  logic              wdt_event_q;
  logic              trap_event_q;
  logic              osc_slow_q;
  int                stage_exp;

  // apb decode: zero-wait writes and reads
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign code    = pwdata[7:0];
  assign cfg     = pwdata[7:0];
  assign pslverr = psel && penable
                   && paddr != wdt_pkg::cfg_offset
                   && paddr != wdt_pkg::code_offset
                   && paddr != wdt_pkg::status_offset
                   && paddr != wdt_pkg::fetch_offset;

  // configuration register fields
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      enable_bit_q           <= 1'b1;
      output_select_bit_q    <= 1'b1;
      detection_time_field_q <= 2'b00;
      trap_response_bit_q    <= 1'b1;
      ram_trap_pending_q     <= 1'b1;
      divider_source_select_q <= 1'b0;
    end
    else if (wr_en && paddr == wdt_pkg::cfg_offset)
    begin
      enable_bit_q           <= cfg[wdt_pkg::enable_pos];
      detection_time_field_q <= cfg[wdt_pkg::time_lsb_pos +: 2]; // RULE3
      // once cleared the output select cannot return to reset
      output_select_bit_q    <= output_select_bit_q
                                && cfg[wdt_pkg::out_sel_pos]; // RULE18
      trap_response_bit_q    <= cfg[wdt_pkg::trap_resp_pos]; // RULE12
      ram_trap_pending_q     <= cfg[wdt_pkg::ram_trap_pos];
      divider_source_select_q <= cfg[wdt_pkg::div_src_pos];
    end
  end

  // ram-trap select takes the staged value on the arm code
  always_ff @(posedge clock)
  begin
    if (!nrst)
      ram_trap_select_bit_q <= 1'b1;
    else if (wr_en && paddr == wdt_pkg::code_offset
             && code == wdt_pkg::trap_arm_code) // RULE9
      ram_trap_select_bit_q <= ram_trap_pending_q; // RULE10
  end

  // watchdog run state: disable code only honoured with enable bit low
  always_ff @(posedge clock)
  begin
    if (!nrst)
      wdt_on_q <= 1'b1;
    else if (enable_bit_q)
      wdt_on_q <= 1'b1;
    else if (wr_en && paddr == wdt_pkg::code_offset
             && code == wdt_pkg::disable_code) // RULE9 RULE17
      wdt_on_q <= 1'b0;
  end

  // fast-clock tick generator from system clock
  always_ff @(posedge clock)
  begin
    if (!nrst || fc_tick)
      fc_cnt_q <= '0;
    else
      fc_cnt_q <= fc_cnt_q + DIV_W'(1);
  end

  assign fc_tick = (fc_cnt_q == DIV_W'(FC_DIV - 1));

  // tap bit: full period minus the two binary-counter bits, minus one
  // more since a prescaler bit falls only once per two of its periods
  always_comb
  begin
    if (slow_mode || divider_source_select_q)
      stage_exp = wdt_pkg::slow_exp_00 - 2 * int'(detection_time_field_q)
                  - wdt_pkg::binary_bits - 1; // RULE3
    else
      stage_exp = wdt_pkg::fast_exp_00 - 2 * int'(detection_time_field_q)
                  - wdt_pkg::binary_bits - 1; // RULE3
  end

  // prescaler runs unless counting_hold is high and is not cleared by the clear code
  always_comb
  begin
    prescale_d = prescale_q;
    if (fc_tick && !counting_hold)
      prescale_d = prescale_q + DIV_W'(1);
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      prescale_q <= '0;
    else
      prescale_q <= prescale_d; // RULE19
  end

  // stage carry each time the tap bit falls, every 2^(stage_exp+1) ticks
  assign stage_tick = fc_tick && !counting_hold
                      && (prescale_d[stage_exp[4:0]]
                          != prescale_q[stage_exp[4:0]])
                      && !prescale_d[stage_exp[4:0]];

  // two-stage binary counter
  always_ff @(posedge clock)
  begin
    if (!nrst)
      binary_q <= 2'b00;
    else if (!wdt_on_q)
      binary_q <= 2'b00; // RULE2
    else if (wr_en && paddr == wdt_pkg::code_offset
             && code == wdt_pkg::clear_code)
      binary_q <= 2'b00; // RULE9 RULE19
    else if (stage_tick)
      binary_q <= binary_q + 2'b01;
  end

  assign overflow = wdt_on_q && stage_tick && binary_q == 2'b11;

  // address trap areas
  assign in_sfr = fetch_addr >= wdt_pkg::sfr_base
                  && fetch_addr <= wdt_pkg::sfr_last;
  assign in_ram = fetch_addr >= wdt_pkg::ram_base
                  && fetch_addr <= wdt_pkg::ram_last;
  assign in_dbg = fetch_addr >= wdt_pkg::dbg_base
                  && fetch_addr <= wdt_pkg::dbg_last;
  assign trap_hit = fetch_valid
                    && (in_sfr || in_dbg // RULE11
                        || (in_ram && ram_trap_select_bit_q)); // RULE13

  // single-cycle non-maskable requests; nesting is up to the core
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      watchdog_irq     <= 1'b0;
      address_trap_irq <= 1'b0;
    end
    else
    begin
      watchdog_irq     <= overflow && !output_select_bit_q; // RULE4 RULE5 RULE6 RULE20
      address_trap_irq <= trap_hit && !trap_response_bit_q
                          && !reset_active; // RULE13 RULE14 RULE20
    end
  end

  // reset request, stretched to the documented length
  assign reset_trigger = (overflow && output_select_bit_q) // RULE8
                         || (trap_hit && trap_response_bit_q); // RULE15

  wdt_pulse_stretch #(
    .LENGTH (wdt_pkg::reset_cycles)
  ) u_reset_stretch (
    .clock   (clock),
    .nrst    (nrst),
    .trigger (reset_trigger),
    .active  (reset_active)
  );

  assign reset_request = reset_active; // RULE8 RULE15

  // remember whether the pending reset was taken in slow mode
  always_ff @(posedge clock)
  begin
    if (!nrst)
      osc_slow_q <= 1'b0;
    else if (reset_trigger)
      osc_slow_q <= slow_mode; // RULE8 RULE15
  end

  // restart stands with the reset request only if it was taken in slow mode, never past it
  assign fast_osc_restart = osc_slow_q && reset_active; // RULE8 RULE15

  // sticky event history and last trapped address for software
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      wdt_event_q      <= 1'b0;
      trap_event_q     <= 1'b0;
      last_trap_addr_q <= 16'h0000;
    end
    else
    begin
      if (overflow)
        wdt_event_q <= 1'b1;
      else if (wr_en && paddr == wdt_pkg::status_offset && pwdata[0])
        wdt_event_q <= 1'b0;
      if (trap_hit)
        trap_event_q <= 1'b1;
      else if (wr_en && paddr == wdt_pkg::status_offset && pwdata[1])
        trap_event_q <= 1'b0;
      if (trap_hit)
        last_trap_addr_q <= fetch_addr;
    end
  end

  // read data registered in the setup cycle; config and code read as zero
  always_ff @(posedge clock)
  begin
    if (!nrst)
      prdata <= 32'h0000_0000;
    else if (rd_en)
    begin
      case (paddr)
        wdt_pkg::status_offset:
          prdata <= {24'h00_0000, binary_q, ram_trap_select_bit_q,
                     output_select_bit_q, wdt_on_q, 1'b0,
                     trap_event_q, wdt_event_q};
        wdt_pkg::fetch_offset:
          prdata <= {16'h0000, last_trap_addr_q};
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : wdt_trap
`default_nettype wire

//--- tb/wdt_trap_props.sv
/* assertions on the ports of wdt_trap.
   bound below to every wdt_trap instance. */
`timescale 1ns/10ps
`default_nettype none
module wdt_trap_props (
  // clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pslverr,
  // fetch
  input wire logic        fetch_valid,
  input wire logic [15:0] fetch_addr,
  // requests
  input wire logic        watchdog_irq,
  input wire logic        address_trap_irq,
  input wire logic        reset_request,
  input wire logic        fast_osc_restart
);
  logic [9:0] len_q;
  logic       hi_f;
  logic       gap_f;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // fetches that always trap, and fetches that never do
  assign hi_f  = fetch_valid && (fetch_addr <= 16'h003F ||
                 (fetch_addr >= 16'h0F80 && fetch_addr <= 16'h0FFF));
  assign gap_f = fetch_valid && fetch_addr > 16'h023F &&
                 fetch_addr < 16'h0F80;
  // clocks the reset request has stood high so far
  always_ff @(posedge clock)
  begin
    if (!nrst || !reset_request)
      len_q <= 10'h000;
    else
      len_q <= len_q + 10'h001;
  end
  chk_wdog_one_pulse:
    assert property (watchdog_irq |=> !watchdog_irq)
    else $error("watchdog request longer than one clock");
  chk_trap_one_pulse:
    assert property (address_trap_irq |=> !address_trap_irq)
    else $error("trap request longer than one clock");
  chk_unmapped_err:
    assert property (psel && penable && paddr > 8'h0C |-> pslverr)
    else $error("unmapped access without error");
  chk_hi_area_trap:
    assert property (hi_f && !reset_request |=>
                     address_trap_irq || reset_request)
    else $error("fetch from register area not trapped");
  chk_gap_quiet:
    assert property (gap_f |=> !address_trap_irq)
    else $error("fetch outside areas trapped");
  chk_reset_max:
    assert property (len_q <= wdt_pkg::reset_cycles)
    else $error("reset request too long");
  chk_reset_len:
    assert property (!reset_request && len_q != 10'h000 |->
                     len_q == wdt_pkg::reset_cycles)
    else $error("reset request length wrong");
  chk_osc_in_reset:
    assert property (fast_osc_restart |-> reset_request)
    else $error("oscillator restart outside reset");
endmodule : wdt_trap_props
bind wdt_trap wdt_trap_props u_wdt_trap_props (.clock(clock), .nrst(nrst),
  .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
  .watchdog_irq(watchdog_irq), .address_trap_irq(address_trap_irq),
  .reset_request(reset_request), .fast_osc_restart(fast_osc_restart));
`default_nettype wire

//--- tb/wdt_cpu_model.sv
/* cpu side: fetch driver and nmi acceptance counts.
   assumes fetch is called just after a rising clock edge. */
`timescale 1ns/10ps
`default_nettype none
module wdt_cpu_model (
  // clock
  input  wire logic   clock,
  // fetch bus
  output logic        fetch_valid,
  output logic [15:0] fetch_addr,
  // nmi requests
  input  wire logic   watchdog_irq,
  input  wire logic   address_trap_irq
);
  int n_wdog;
  int n_trap;
  initial
  begin
    fetch_valid = 1'b0;
    fetch_addr  = 16'h5A5A;
    n_wdog      = 0;
    n_trap      = 0;
  end
  // every pulse taken at once, no mask, nesting unbounded
  always @(posedge clock)
  begin
    n_wdog <= n_wdog + watchdog_irq;
    n_trap <= n_trap + address_trap_irq;
  end
  // one fetch cycle; the address bus shows the inverse afterwards
  task automatic fetch(input logic [15:0] a);
    @(posedge clock);
    fetch_valid <= 1'b1;
    fetch_addr  <= a;
    @(posedge clock);
    fetch_valid <= 1'b0;
    fetch_addr  <= ~a;
  endtask : fetch
endmodule : wdt_cpu_model
`default_nettype wire

//--- tb/wdt_trap_tb_top.sv
/* bench for wdt_trap: apb master, cpu model, reference counts.
   assumes FC_DIV of 1 and the area map of wdt_pkg. */
`timescale 1ns/10ps
`default_nettype none
module wdt_trap_tb_top;
  logic        clock, nrst, psel, penable, pwrite, slow_mode;
  logic        pready, pslverr, err, fv, wirq, tirq, rreq, osc;
  logic [7:0]  paddr;
  logic [15:0] fa;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, checked, ram_act, n, k, a, last;
  wdt_trap #(.FC_DIV(1)) u_wdt_trap (.clock(clock), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_valid(fv), .fetch_addr(fa), .slow_mode(slow_mode),
    .counting_hold(1'b0), .watchdog_irq(wirq), .address_trap_irq(tirq),
    .reset_request(rreq), .fast_osc_restart(osc));
  wdt_cpu_model u_wdt_cpu_model (.clock(clock), .fetch_valid(fv),
    .fetch_addr(fa), .watchdog_irq(wirq), .address_trap_irq(tirq));
  // 250 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic check(input string s, input logic [31:0] v, e);
    checked++;
    if (v !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", s, e, v);
    end
  endtask : check
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    for (k = 0; pready !== 1'b1 && k < 50; k++)
      @(posedge clock);
    if (k == 50)
    begin
      n_mismatch++;
      final_report();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  // reference trap map
  function automatic int hit(input int x);
    return x <= 16'h003F || (x >= 16'h0F80 && x <= 16'h0FFF) ||
           (ram_act != 0 && x >= 16'h0040 && x <= 16'h023F);
  endfunction : hit
  // fixed then random fetches, trap count against the map
  task automatic sweep;
    logic [15:0] t [4] = '{16'h0040, 16'h0010, 16'h0F90, 16'h0500};
    for (int i = 0; i < 30; i++)
    begin
      a = (i < 4) ? t[i] : $urandom_range(16'h0FFF);
      n = u_wdt_cpu_model.n_trap;
      u_wdt_cpu_model.fetch(a[15:0]);
      repeat (2) @(posedge clock);
      check("trap", u_wdt_cpu_model.n_trap - n, hit(a));
      if (hit(a) != 0)
        last = a;
    end
  endtask : sweep
  // clocks until the next watchdog pulse, at most 3000
  task automatic wdog_wait;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wirq !== 1'b1 && n < 3000);
  endtask : wdog_wait
  // waits for a reset request, checks its length and restart flag
  task automatic reset_len(input int lim, input logic o);
    for (n = 0; rreq !== 1'b1 && n < lim; n++)
      @(posedge clock);
    check("reset seen", n < lim, 1);
    for (k = 0; rreq === 1'b1 && k < 500; k++)
    begin
      @(posedge clock);
      if (k == 9)
        check("osc", osc, o);
    end
    check("reset len", k, wdt_pkg::reset_cycles);
  endtask : reset_len
  task automatic do_reset;
    nrst <= 1'b0;
    repeat (6) @(posedge clock);
    nrst    <= 1'b1;
    ram_act = 1;
    @(posedge clock);
  endtask : do_reset
  // main sequence
  initial
  begin
    {psel, penable, pwrite, slow_mode, nrst} = 5'h00;
    paddr  = 8'h00;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    checked    = 0;
    last       = 0;
    void'($urandom(60));
    do_reset();
    apb(1'b0, 8'h08, 32'h0);
    check("status", rd, 32'h38);
    apb(1'b0, 8'h10, 32'h0);
    check("slverr", err, 1);
    apb(1'b1, 8'h00, 32'h4E);
    apb(1'b0, 8'h08, 32'h0);
    check("staged", rd[5:4], 2'b10);
    sweep();
    apb(1'b1, 8'h04, 32'hD2);
    ram_act = 0;
    sweep();
    apb(1'b0, 8'h0C, 32'h0);
    check("trap addr", rd, last);
    apb(1'b0, 8'h08, 32'h0);
    check("events", rd[1:0], 2'b10);
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b0, 8'h08, 32'h0);
    check("events clear", rd[1:0], 2'b00);
    apb(1'b1, 8'h04, 32'h4E);
    wdog_wait();
    check("first ovf", n >= 1530 && n <= 2048, 1);
    wdog_wait();
    check("period", n, 2048);
    apb(1'b1, 8'h04, 32'hB1);
    apb(1'b0, 8'h08, 32'h0);
    check("running", rd[3], 1);
    apb(1'b1, 8'h04, 32'h4E);
    apb(1'b1, 8'h00, 32'h47);
    apb(1'b1, 8'h04, 32'hB1);
    wdog_wait();
    check("silent", n, 3000);
    apb(1'b0, 8'h08, 32'h0);
    check("stopped", {rd[7:6], rd[4:3]}, 0);
    apb(1'b1, 8'h00, 32'h57);
    slow_mode <= 1'b1;
    u_wdt_cpu_model.fetch(16'h0010);
    reset_len(20, 1'b1);
    slow_mode <= 1'b0;
    do_reset();
    apb(1'b1, 8'h00, 32'h4F);
    apb(1'b1, 8'h04, 32'h4E);
    reset_len(2200, 1'b0);
    final_report();
  end
endmodule : wdt_trap_tb_top
`default_nettype wire
